/* hw/dbes_regs.vh */
// event codes, unit masks and field layout for the event selector
`ifndef DBES_REGS_VH
`define DBES_REGS_VH
`define DBES_EVT_DIV 8'h13
`define DBES_EVT_DIV_BUSY 8'h14
`define DBES_EVT_DIV_IDLE 8'h18
`define DBES_EVT_BYPASS 8'h19
`define DBES_EVT_L2_ADDR 8'h21
`define DBES_EVT_L2_RDATA 8'h23
`define DBES_UM_ZERO 8'h00
`define DBES_UM_FLOAT 8'h00
`define DBES_UM_VECTOR 8'h01
`define DBES_UM_LOAD 8'h02
`define DBES_UM_CORE_HI 7
`define DBES_UM_CORE_LO 6
`define DBES_UM_CORE_BOTH 2'h3
`define DBES_CNT_W 40
`endif

/* hw/dbes_counter.v */
// one general counter with a selected increment
`timescale 1ns/100ps
module dbes_counter #(
   parameter CNT_W = 40
) (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // control
   input wire i_clear,
   input wire [1:0] i_inc,
   // count
   output reg [CNT_W-1:0] o_count
);
   always @(posedge i_clk) begin
      if (i_srst || i_clear) begin
         o_count <= {CNT_W{1'b0}};
      end else begin
         o_count <= o_count + {{(CNT_W-2){1'b0}}, i_inc};
      end
   end
endmodule // dbes_counter

/* hw/dbes_event_select.v */
// event selection for general counters zero and one
`timescale 1ns/100ps
`include "dbes_regs.vh"
// Behaviour
// - code 13h mask 00h counts every divide, square root too, counter one.
// - code 14h counts divider busy cycles, counter zero only.
// - code 18h counts divider busy with no op issued after its start, counter zero.
// - idle test looks only at ops after divide start; loads hit.
// - code 19h mask 00h counts float bypass penalties, counter one.
// - code 19h mask 01h counts vector bypass penalties, counter one.
// - code 19h mask 02h counts load bypass penalty cycles, counter one.
// - code 21h counts address bus cycles, this core or both cores.
// - code 23h counts read data bus cycles, this core or both.
module dbes_event_select #(
   parameter CNT_W = `DBES_CNT_W
) (
   // clock and reset
   input wire i_clk,
   input wire i_srst,
   // counter zero selection
   input wire i_en0,
   input wire [7:0] i_evt0,
   input wire [7:0] i_um0,
   input wire i_clear0,
   // counter one selection
   input wire i_en1,
   input wire [7:0] i_evt1,
   input wire [7:0] i_um1,
   input wire i_clear1,
   // execution unit events
   input wire i_div_done,
   input wire i_div_start,
   input wire i_div_busy,
   input wire i_other_unit_busy,
   input wire i_other_after_start,
   input wire i_load_active,
   input wire i_float_bypass_penalty,
   input wire i_vector_bypass_penalty,
   input wire i_load_bypass_penalty,
   // second level cache events
   input wire i_addr_bus_this,
   input wire i_addr_bus_other,
   input wire i_rdata_bus_this,
   input wire i_rdata_bus_other,
   // counts
   output wire [CNT_W-1:0] o_general_counter_zero,
   output wire [CNT_W-1:0] o_general_counter_one
);
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   function [1:0] one_inc;
      input ev;
      begin
         one_inc = {1'b0, ev};
      end
   endfunction

   function [1:0] core_sum;
      input [7:0] um;
      input this_c;
      input other_c;
      begin
         if (um[`DBES_UM_CORE_HI:`DBES_UM_CORE_LO] == `DBES_UM_CORE_BOTH)
            core_sum = one_inc(this_c) + one_inc(other_c);
         else
            core_sum = one_inc(this_c);
      end
   endfunction

   function mask_is;
      input [7:0] um;
      input [7:0] want;
      begin
         mask_is = (um == want);
      end
   endfunction

   // ----------------------------------------
   // divider idle tracking
   // ----------------------------------------
   reg div_window_r;
   reg div_window_nxt;

   always @* begin
      div_window_nxt = div_window_r;
      if (i_div_start) begin
         div_window_nxt = 1'b1;
      end else if (!i_div_busy) begin
         div_window_nxt = 1'b0;
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         div_window_r <= 1'b0;
      end else begin
         div_window_r <= div_window_nxt;
      end
   end

   // older ops dispatched before the start are ignored; loads assumed hit
   wire late_load = i_load_active && i_other_after_start;
   wire late_work = i_other_after_start || late_load;
   wire div_idle = i_div_busy && div_window_r && !late_work;

   // ----------------------------------------
   // counter zero selection
   // ----------------------------------------
   reg [1:0] inc0_r;
   reg [1:0] inc0_nxt;

   always @* begin
      inc0_nxt = 2'h0;
      if (i_en0) begin
         case (i_evt0)
            `DBES_EVT_DIV_BUSY: begin
               if (mask_is(i_um0, `DBES_UM_ZERO))
                  inc0_nxt = one_inc(i_div_busy);
               else
                  inc0_nxt = 2'h0;
            end
            `DBES_EVT_DIV_IDLE: begin
               if (mask_is(i_um0, `DBES_UM_ZERO))
                  inc0_nxt = one_inc(div_idle);
               else
                  inc0_nxt = 2'h0;
            end
            `DBES_EVT_L2_ADDR: begin
               inc0_nxt = core_sum(i_um0, i_addr_bus_this,
                  i_addr_bus_other);
            end
            `DBES_EVT_L2_RDATA: begin
               inc0_nxt = core_sum(i_um0, i_rdata_bus_this,
                  i_rdata_bus_other);
            end
            default: begin
               // divide and bypass events never reach counter zero
               inc0_nxt = 2'h0;
            end
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         inc0_r <= 2'h0;
      end else begin
         inc0_r <= inc0_nxt;
      end
   end

   // ----------------------------------------
   // counter one selection
   // ----------------------------------------
   reg [1:0] inc1_r;
   reg [1:0] inc1_nxt;

   always @* begin
      inc1_nxt = 2'h0;
      if (i_en1) begin
         case (i_evt1)
            `DBES_EVT_DIV: begin
               if (mask_is(i_um1, `DBES_UM_ZERO))
                  inc1_nxt = one_inc(i_div_done);
               else
                  inc1_nxt = 2'h0;
            end
            `DBES_EVT_BYPASS: begin
               if (mask_is(i_um1, `DBES_UM_FLOAT))
                  inc1_nxt = one_inc(i_float_bypass_penalty);
               else if (mask_is(i_um1, `DBES_UM_VECTOR))
                  inc1_nxt = one_inc(i_vector_bypass_penalty);
               else if (mask_is(i_um1, `DBES_UM_LOAD))
                  inc1_nxt = one_inc(i_load_bypass_penalty);
               else
                  inc1_nxt = 2'h0;
            end
            `DBES_EVT_L2_ADDR: begin
               inc1_nxt = core_sum(i_um1, i_addr_bus_this,
                  i_addr_bus_other);
            end
            `DBES_EVT_L2_RDATA: begin
               inc1_nxt = core_sum(i_um1, i_rdata_bus_this,
                  i_rdata_bus_other);
            end
            default: begin
               // busy and idle cycles never reach counter one
               inc1_nxt = 2'h0;
            end
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         inc1_r <= 2'h0;
      end else begin
         inc1_r <= inc1_nxt;
      end
   end

   // ----------------------------------------
   // counter zero storage
   // ----------------------------------------
   dbes_counter #(.CNT_W(CNT_W)) u_cnt0 (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_clear(i_clear0),
      .i_inc(inc0_r),
      .o_count(o_general_counter_zero)
   );

   // ----------------------------------------
   // counter one storage
   // ----------------------------------------
   dbes_counter #(.CNT_W(CNT_W)) u_cnt1 (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_clear(i_clear1),
      .i_inc(inc1_r),
      .o_count(o_general_counter_one)
   );
endmodule // dbes_event_select

/* bench/dbes_chk.sv */
// assertions on the event selector ports
`timescale 1ns/100ps
module dbes_chk (
   input wire i_clk, i_srst, i_en0, i_en1, i_clear0, i_clear1,
   input wire [7:0] i_evt0, i_um0, i_evt1, i_um1,
   input wire i_div_done, i_div_start, i_div_busy, i_other_after_start,
   input wire i_float_bypass_penalty, i_vector_bypass_penalty,
   input wire i_load_bypass_penalty, i_addr_bus_this, i_addr_bus_other,
   input wire i_rdata_bus_this, i_rdata_bus_other,
   input wire [39:0] o_general_counter_zero, o_general_counter_one
);
   wire [15:0] s0 = i_en0 ? {i_evt0, i_um0} : 16'h0;
   wire [15:0] s1 = i_en1 ? {i_evt1, i_um1} : 16'h0;
   property p0(c, n);
      @(posedge i_clk) disable iff (i_srst) c && !i_clear0 ##1 !i_clear0
      |-> ##1 o_general_counter_zero == $past(o_general_counter_zero) + n;
   endproperty
   property p1(c, n);
      @(posedge i_clk) disable iff (i_srst) c && !i_clear1 ##1 !i_clear1
      |-> ##1 o_general_counter_one == $past(o_general_counter_one) + n;
   endproperty
   a_div_count: assert property (
      p1(s1==16'h1300 && i_div_done, 1))
      else $error("divide count wrong");
   a_wrong_ctr: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (s0==16'h1300 && !i_clear0) [*3] |-> $stable(o_general_counter_zero))
      else $error("divide counted on counter zero");
   a_busy_count: assert property (
      p0(s0==16'h1400 && i_div_busy, 1))
      else $error("busy count wrong");
   a_busy_quiet: assert property (
      p0(s0==16'h1400 && !i_div_busy, 0))
      else $error("idle divider counted");
   a_idle_block: assert property (
      p0(s0==16'h1800 && i_other_after_start, 0))
      else $error("idle counted with other work");
   a_idle_count: assert property (
      @(posedge i_clk) disable iff (i_srst)
      s0==16'h1800 && i_div_busy && !i_other_after_start &&
      $past(i_div_start) && !$past(i_srst) && !i_clear0 ##1 !i_clear0
      |-> ##1 o_general_counter_zero == $past(o_general_counter_zero) + 1)
      else $error("idle divide cycle not counted");
   a_fp_bypass: assert property (
      p1(s1==16'h1900 && i_float_bypass_penalty, 1))
      else $error("float bypass count wrong");
   a_vec_bypass: assert property (
      p1(s1==16'h1901 && i_vector_bypass_penalty, 1))
      else $error("vector bypass count wrong");
   a_ld_bypass: assert property (
      p1(s1==16'h1902 && i_load_bypass_penalty, 1))
      else $error("load bypass count wrong");
   a_addr_both: assert property (
      p0(s0==16'h21C0 && i_addr_bus_this && i_addr_bus_other, 2))
      else $error("both core address count wrong");
   a_rdata_this: assert property (
      p0(s0==16'h2300 && i_rdata_bus_this && i_rdata_bus_other, 1))
      else $error("this core data count wrong");
   c_div: cover property (@(posedge i_clk) s1==16'h1300 && i_div_done);
   c_load: cover property (@(posedge i_clk)
      s1==16'h1902 && i_load_bypass_penalty);
   c_idle: cover property (@(posedge i_clk) s0==16'h1800 && i_div_busy);
   c_both: cover property (@(posedge i_clk) s0==16'h21C0 && i_addr_bus_other);
endmodule // dbes_chk
bind dbes_event_select dbes_chk i_chk (.*);

/* bench/dbes_src.sv */
// event source model: holds a pattern for five cycles
`timescale 1ns/100ps
module dbes_src (
   input wire i_clk,
   input wire i_go,
   input wire [12:0] i_pat,
   output reg [12:0] o_ev
);
   reg [2:0] left_r = 3'h0;
   initial o_ev = 13'h0;
   always @(posedge i_clk) begin
      left_r <= i_go ? 3'h5 : left_r - {2'h0, left_r != 3'h0};
      o_ev <= #1 (i_go || left_r > 3'h1) ? i_pat : 13'h0;
   end
endmodule // dbes_src

/* bench/tb.sv */
// self-checking bench for the event selector
`timescale 1ns/100ps
module tb;
   reg i_clk = 1'b0, i_srst = 1'b1, en = 1'b1, cl = 1'b0, go = 1'b0;
   reg [15:0] s0 = 16'h0, s1 = 16'h0, bs = 16'h0;
   reg [12:0] pat = 13'h0;
   wire [12:0] ev;
   wire [39:0] c0, c1;
   integer fail_count = 0, tests_run = 0, m;
   initial forever #5 i_clk = ~i_clk;
   dbes_src i_src (.i_clk(i_clk), .i_go(go), .i_pat(pat), .o_ev(ev));
   dbes_event_select i_dut (.i_clk(i_clk), .i_srst(i_srst),
      .i_en0(en), .i_evt0(s0[15:8]), .i_um0(s0[7:0]), .i_clear0(cl),
      .i_en1(en), .i_evt1(s1[15:8]), .i_um1(s1[7:0]), .i_clear1(cl),
      .i_div_done(ev[12]), .i_div_start(ev[11]), .i_div_busy(ev[10]),
      .i_other_unit_busy(ev[9]), .i_other_after_start(ev[8]),
      .i_load_active(ev[7]), .i_float_bypass_penalty(ev[6]),
      .i_vector_bypass_penalty(ev[5]), .i_load_bypass_penalty(ev[4]),
      .i_addr_bus_this(ev[3]), .i_addr_bus_other(ev[2]),
      .i_rdata_bus_this(ev[1]), .i_rdata_bus_other(ev[0]),
      .o_general_counter_zero(c0), .o_general_counter_one(c1));
   task test_done;
      begin
         $display("compares %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task cmp(input [39:0] got, input [39:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t count %0d want %0d", $time, got, exp);
         end
      end
   endtask
   // select, clear, run five source cycles, then compare both counts
   task meas(input [15:0] a, b, input [12:0] p, input [39:0] e0, e1);
      begin
         @(posedge i_clk) #1;
         s0 = a;
         s1 = b;
         pat = p;
         cl = 1'b1;
         @(posedge i_clk) #1;
         cl = 1'b0;
         go = 1'b1;
         @(posedge i_clk) #1;
         go = 1'b0;
         repeat (8) @(posedge i_clk);
         #1 cmp(c0, e0);
         cmp(c1, e1);
         $display("case %h %h done", a, b);
      end
   endtask
   task t_div;
      meas(16'h1300, 16'h1300, 13'h1000, 40'h0, 40'h5);
   endtask
   task t_busy;
      meas(16'h1400, 16'h1400, 13'h0400, 40'h5, 40'h0);
   endtask
   task t_idle;
      begin
         meas(16'h1800, 16'h1800, 13'h0D80, 40'h0, 40'h0);
         meas(16'h1800, 16'h1800, 13'h0E80, 40'h4, 40'h0);
      end
   endtask
   task t_byp;
      for (m = 0; m < 3; m = m + 1) begin
         bs = {8'h19, m[7:0]};
         meas(bs, bs, 13'h40 >> m, 0, 5);
         meas(bs, bs, 13'h70 ^ (13'h40 >> m), 0, 0);
      end
   endtask
   task t_bus;
      begin
         meas(16'h21C0, 16'h2100, 13'h000C, 40'hA, 40'h5);
         meas(16'h2300, 16'h23C0, 13'h0003, 40'h5, 40'hA);
      end
   endtask
   task t_off;
      begin
         en = 1'b0;
         meas(16'h1400, 16'h1300, 13'h1400, 40'h0, 40'h0);
         en = 1'b1;
      end
   endtask
   initial begin
      #5000;
      fail_count = fail_count + 1;
      test_done;
   end
   initial begin
      repeat (20) @(posedge i_clk);
      #1 i_srst = 1'b0;
      cmp(c0, 40'h0);
      cmp(c1, 40'h0);
      t_div;
      t_busy;
      t_idle;
      t_byp;
      t_bus;
      t_off;
      test_done;
   end
endmodule // tb
